// file: jtag_tap_consts.svh
`ifndef JTAG_TAP_CONSTS_SVH
`define JTAG_TAP_CONSTS_SVH

// chain geometry: pins from the tdi end, three cells per two-way pin
`define CHAIN_PINS      56
`define CHAIN_CELLS     166
// zero-based pin index of the lone input-only pin (one cell)
`define INPUT_ONLY_PIN  48
// cell order inside one two-way pin, counted from the tdi end
`define CELL_IN         0
`define CELL_OUT        1
`define CELL_EN         2
`define CELLS_PER_PIN   3

// per-cell constant values (in, out, enable) loaded into the update stage
`define BSR_SAFE        166'hc106c00c

// instruction register
`define IR_W            3
`define IR_EXTEST       3'h0
`define IR_SAMPLE       3'h2
`define IR_BYPASS       3'h7
`define IR_CAPTURE      3'h1

// pad pull-up enables for tms, tdi and trst
`define PULLUP_ON       3'h7

`endif

// file: jtag_tap_pkg.sv
package jtag_tap_pkg;

    // sixteen controller states, one-hot
    typedef enum logic [15:0] {
        ST_RESET    = 16'h0001,
        ST_IDLE     = 16'h0002,
        ST_SEL_DR   = 16'h0004,
        ST_CAP_DR   = 16'h0008,
        ST_SHIFT_DR = 16'h0010,
        ST_EXIT1_DR = 16'h0020,
        ST_PAUSE_DR = 16'h0040,
        ST_EXIT2_DR = 16'h0080,
        ST_UPD_DR   = 16'h0100,
        ST_SEL_IR   = 16'h0200,
        ST_CAP_IR   = 16'h0400,
        ST_SHIFT_IR = 16'h0800,
        ST_EXIT1_IR = 16'h1000,
        ST_PAUSE_IR = 16'h2000,
        ST_EXIT2_IR = 16'h4000,
        ST_UPD_IR   = 16'h8000
    } tap_state_t;

endpackage

// file: tap_ctrl_if.sv
`timescale 1ns/1ps
`include "jtag_tap_consts.svh"

// decoded controller strobes handed to the scan chain
interface tap_ctrl_if;
    logic             test_reset;  // controller in test-logic-reset
    logic             capture_dr;  // capture-dr state
    logic             shift_dr;    // shift-dr state
    logic             update_dr;   // update-dr state
    logic             shift_ir;    // shift-ir state
    logic             ir_tdo;      // instruction shifter serial out
    logic [`IR_W-1:0] instr;       // active instruction

    modport ctrl (
        output test_reset, capture_dr, shift_dr, update_dr, shift_ir, ir_tdo, instr
    );
    modport user (
        input  test_reset, capture_dr, shift_dr, update_dr, shift_ir, ir_tdo, instr
    );
endinterface

// file: tap_fsm.sv
`timescale 1ns/1ps
`include "jtag_tap_consts.svh"

module tap_fsm
    import jtag_tap_pkg::*;
(
    input  wire logic i_tck,     // test clock
    input  wire logic i_trst_n,  // test reset, async, low active
    input  wire logic i_tms,     // mode select
    input  wire logic i_tdi,     // serial data in
    tap_ctrl_if.ctrl  ctl        // strobes to the chain
);

    // whole controller state
    typedef struct packed {
        tap_state_t       state;  // controller state
        logic [`IR_W-1:0] ir_sr;  // instruction shifter
        logic [`IR_W-1:0] ir;     // active instruction
    } fsm_t;

    localparam fsm_t FSM_RESET = '{state: ST_RESET, ir_sr: `IR_CAPTURE, ir: `IR_BYPASS};

    fsm_t fsm_reg;   // registered state
    fsm_t fsm_next;  // next state

    // standard sixteen-state walk on one tms bit
    function automatic tap_state_t next_state(input tap_state_t s, input logic tms);
        case (s)
            ST_RESET:    next_state = tms ? ST_RESET    : ST_IDLE;
            ST_IDLE:     next_state = tms ? ST_SEL_DR   : ST_IDLE;
            ST_SEL_DR:   next_state = tms ? ST_SEL_IR   : ST_CAP_DR;
            ST_CAP_DR:   next_state = tms ? ST_EXIT1_DR : ST_SHIFT_DR;
            ST_SHIFT_DR: next_state = tms ? ST_EXIT1_DR : ST_SHIFT_DR;
            ST_EXIT1_DR: next_state = tms ? ST_UPD_DR   : ST_PAUSE_DR;
            ST_PAUSE_DR: next_state = tms ? ST_EXIT2_DR : ST_PAUSE_DR;
            ST_EXIT2_DR: next_state = tms ? ST_UPD_DR   : ST_SHIFT_DR;
            ST_UPD_DR:   next_state = tms ? ST_SEL_DR   : ST_IDLE;
            ST_SEL_IR:   next_state = tms ? ST_RESET    : ST_CAP_IR;
            ST_CAP_IR:   next_state = tms ? ST_EXIT1_IR : ST_SHIFT_IR;
            ST_SHIFT_IR: next_state = tms ? ST_EXIT1_IR : ST_SHIFT_IR;
            ST_EXIT1_IR: next_state = tms ? ST_UPD_IR   : ST_PAUSE_IR;
            ST_PAUSE_IR: next_state = tms ? ST_EXIT2_IR : ST_PAUSE_IR;
            ST_EXIT2_IR: next_state = tms ? ST_UPD_IR   : ST_SHIFT_IR;
            ST_UPD_IR:   next_state = tms ? ST_SEL_DR   : ST_IDLE;
            default:     next_state = ST_RESET;  // illegal code recovers
        endcase
    endfunction

    // next state and instruction handling
    always_comb begin
        fsm_next = fsm_reg;
        fsm_next.state = next_state(fsm_reg.state, i_tms);
        case (fsm_reg.state)
            // five tms highs always land here and drop back to bypass
            ST_RESET: begin
                fsm_next.ir = `IR_BYPASS;
            end
            ST_CAP_IR: begin
                fsm_next.ir_sr = `IR_CAPTURE;
            end
            ST_SHIFT_IR: begin
                fsm_next.ir_sr = {i_tdi, fsm_reg.ir_sr[`IR_W-1:1]};
            end
            ST_UPD_IR: begin
                fsm_next.ir = fsm_reg.ir_sr;
            end
            default: begin
            end
        endcase
    end

    // tms and tdi taken on rising tck; trst wins at any time
    always_ff @(posedge i_tck or negedge i_trst_n) begin
        if (!i_trst_n) begin
            fsm_reg <= FSM_RESET;
        end else begin
            fsm_reg <= fsm_next;
        end
    end

    // decoded strobes
    assign ctl.test_reset = (fsm_reg.state == ST_RESET);
    assign ctl.capture_dr = (fsm_reg.state == ST_CAP_DR);
    assign ctl.shift_dr   = (fsm_reg.state == ST_SHIFT_DR);
    assign ctl.update_dr  = (fsm_reg.state == ST_UPD_DR);
    assign ctl.shift_ir   = (fsm_reg.state == ST_SHIFT_IR);
    assign ctl.ir_tdo     = fsm_reg.ir_sr[0];
    assign ctl.instr      = fsm_reg.ir;

endmodule

// file: jtag_boundary_scan_tap.sv
`timescale 1ns/1ps
`include "jtag_tap_consts.svh"

// Notes on behaviour
// - sixteen-state controller selects scan modes
// - controller and chain follow standard 1149.1
// - scan works only while trst high
// - pull-ups on tms, tdi and trst
// - tms walks states; tms high means normal
// - chain starts at tdi, 166 positions on fifty-six pins
// - three cells per two-way pin, constants

module jtag_boundary_scan_tap
    import jtag_tap_pkg::*;
(
    input  wire logic                   i_clock,      // system clock
    input  wire logic                   i_reset,      // system reset, sync
    input  wire logic                   i_tck,        // test clock
    input  wire logic                   i_trst_n,     // test reset, low active
    input  wire logic                   i_tms,        // test mode select
    input  wire logic                   i_tdi,        // test data in
    output logic                        o_tdo,        // test data out
    output logic                        o_tdo_oe_n,   // tdo enable, low drives
    output logic [2:0]                  o_pullup_en,  // pad pull-ups tms/tdi/trst
    output logic                        o_test_active,// extest owns the pins
    input  wire logic [`CHAIN_PINS-1:0] i_core_out,   // core drive values
    input  wire logic [`CHAIN_PINS-1:0] i_core_oe,    // core drive enables
    output logic [`CHAIN_PINS-1:0]      o_core_in,    // pin levels to core
    input  wire logic [`CHAIN_PINS-1:0] i_pad_in,     // pin levels
    output logic [`CHAIN_PINS-1:0]      o_pad_out,    // pin drive values
    output logic [`CHAIN_PINS-1:0]      o_pad_oe_n    // pin enables, low drives
);

    localparam int NP = `CHAIN_PINS;
    localparam int NC = `CHAIN_CELLS;
    localparam int NM = 3 * NP;

    // tck rising-edge state
    typedef struct packed {
        logic [NM-1:0] mon_s1;    // first sync stage, only feeds s2
        logic [NM-1:0] mon_s2;    // second sync stage
        logic [NM-1:0] mon_s3;    // third sync stage
        logic [NM-1:0] mon_ok;    // value accepted after s2/s3 agree
        logic [NC-1:0] shift_sr;  // boundary shift stage
        logic [NC-1:0] upd;       // boundary update stage
        logic          bypass;    // one-bit bypass
    } scan_t;

    // tck falling-edge state
    typedef struct packed {
        logic tdo;     // launched serial bit
        logic tdo_oe_n;// output enable, low while shifting
    } out_t;

    // system clock state
    typedef struct packed {
        logic ext_s1;  // first sync stage, only feeds s2
        logic ext_s2;  // second sync stage
        logic ext_s3;  // third sync stage
        logic ext_ok;  // extest level accepted after s2/s3 agree
    } sys_t;

    localparam scan_t SCAN_RESET = '{upd: `BSR_SAFE, default: '0};
    localparam out_t  OUT_RESET  = '{tdo: 1'b0, tdo_oe_n: 1'b1};
    localparam sys_t  SYS_RESET  = '{default: 1'b0};

    scan_t scan_reg;   // rising-edge registers
    scan_t scan_next;  // their next value
    out_t  out_reg;    // falling-edge registers
    out_t  out_next;   // their next value
    sys_t  sys_reg;    // system domain registers
    sys_t  sys_next;   // their next value

    logic             bsr_sel;  // boundary register selected
    logic             extest;   // chain owns the pins
    logic [NP-1:0]    ok_pad;   // accepted pin levels
    logic [NP-1:0]    ok_out;   // accepted core drive
    logic [NP-1:0]    ok_oe;    // accepted core enable

    tap_ctrl_if ctl_bus ();  // controller strobes

    // controller and instruction register
    tap_fsm u_fsm (
        .i_tck    (i_tck),
        .i_trst_n (i_trst_n),
        .i_tms    (i_tms),
        .i_tdi    (i_tdi),
        .ctl      (ctl_bus)
    );

    // first cell of pin p counted from the tdi end; one pin has a single cell
    function automatic int cell_base(input int p);
        if (p <= `INPUT_ONLY_PIN) begin
            cell_base = `CELLS_PER_PIN * p;
        end else begin
            cell_base = `CELLS_PER_PIN * p - (`CELLS_PER_PIN - 1);
        end
    endfunction

    // parallel capture word: pin level, core drive, core enable per pin
    function automatic logic [NC-1:0] capture_vec(input logic [NP-1:0] pad,
                                                  input logic [NP-1:0] cout,
                                                  input logic [NP-1:0] coe);
        logic [NC-1:0] v;
        v = '0;
        for (int p = 0; p < NP; p++) begin
            if (p == `INPUT_ONLY_PIN) begin
                v[cell_base(p)] = pad[p];
            end else begin
                v[cell_base(p) + `CELL_IN]  = pad[p];
                v[cell_base(p) + `CELL_OUT] = cout[p];
                v[cell_base(p) + `CELL_EN]  = coe[p];
            end
        end
        return v;
    endfunction

    assign bsr_sel = (ctl_bus.instr == `IR_EXTEST) || (ctl_bus.instr == `IR_SAMPLE);
    assign extest  = (ctl_bus.instr == `IR_EXTEST);
    assign {ok_pad, ok_out, ok_oe} = scan_reg.mon_ok;

    // chain shifting, capture and update on rising tck
    always_comb begin
        scan_next = scan_reg;
        // pins and core signals are foreign to tck; three stages, then agree
        scan_next.mon_s1 = {i_pad_in, i_core_out, i_core_oe};
        scan_next.mon_s2 = scan_reg.mon_s1;
        scan_next.mon_s3 = scan_reg.mon_s2;
        scan_next.mon_ok = (scan_reg.mon_s3 & ~(scan_reg.mon_s2 ^ scan_reg.mon_s3))
                         | (scan_reg.mon_ok & (scan_reg.mon_s2 ^ scan_reg.mon_s3));
        if (ctl_bus.test_reset) begin
            // held here by tms high: chain idle, pins left to the core
            scan_next.upd    = `BSR_SAFE;
            scan_next.bypass = 1'b0;
        end else if (ctl_bus.capture_dr) begin
            scan_next.bypass = 1'b0;
            if (bsr_sel) begin
                scan_next.shift_sr = capture_vec(ok_pad, ok_out, ok_oe);
            end
        end else if (ctl_bus.shift_dr) begin
            if (bsr_sel) begin
                // tdi enters cell 0 (position 1), tdo leaves the far end
                scan_next.shift_sr = {scan_reg.shift_sr[NC-2:0], i_tdi};
            end else begin
                scan_next.bypass = i_tdi;
            end
        end else if (ctl_bus.update_dr && bsr_sel) begin
            scan_next.upd = scan_reg.shift_sr;
        end
    end

    always_ff @(posedge i_tck or negedge i_trst_n) begin
        if (!i_trst_n) begin
            scan_reg <= SCAN_RESET;
        end else begin
            scan_reg <= scan_next;
        end
    end

    // tdo launched half a tck later so the tester samples it on the rise
    always_comb begin
        out_next = out_reg;
        if (ctl_bus.shift_ir) begin
            out_next.tdo = ctl_bus.ir_tdo;
        end else if (bsr_sel) begin
            out_next.tdo = scan_reg.shift_sr[NC-1];
        end else begin
            out_next.tdo = scan_reg.bypass;
        end
        out_next.tdo_oe_n = !(ctl_bus.shift_ir || ctl_bus.shift_dr);
    end

    always_ff @(negedge i_tck or negedge i_trst_n) begin
        if (!i_trst_n) begin
            out_reg <= OUT_RESET;
        end else begin
            out_reg <= out_next;
        end
    end

    // extest level handed to the system clock for the core to see
    always_comb begin
        sys_next        = sys_reg;
        sys_next.ext_s1 = extest;
        sys_next.ext_s2 = sys_reg.ext_s1;
        sys_next.ext_s3 = sys_reg.ext_s2;
        // a decode glitch lasting one clock never makes s2 and s3 agree
        if (sys_reg.ext_s2 == sys_reg.ext_s3) begin
            sys_next.ext_ok = sys_reg.ext_s3;
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            sys_reg <= SYS_RESET;
        end else begin
            sys_reg <= sys_next;
        end
    end

    // pin muxing: update stage drives the pins only under extest
    always_comb begin
        o_pad_out  = '0;
        o_pad_oe_n = '1;
        for (int p = 0; p < NP; p++) begin
            if (p == `INPUT_ONLY_PIN) begin
                // input-only pin: never driven
                o_pad_out[p]  = 1'b0;
                o_pad_oe_n[p] = 1'b1;
            end else if (extest) begin
                o_pad_out[p]  = scan_reg.upd[cell_base(p) + `CELL_OUT];
                o_pad_oe_n[p] = !scan_reg.upd[cell_base(p) + `CELL_EN];
            end else begin
                o_pad_out[p]  = i_core_out[p];
                o_pad_oe_n[p] = !i_core_oe[p];
            end
        end
    end

    // functional inputs pass straight through; sampling does not disturb them
    assign o_core_in     = i_pad_in;
    assign o_tdo         = out_reg.tdo;
    assign o_tdo_oe_n    = out_reg.tdo_oe_n;
    assign o_test_active = sys_reg.ext_ok;
    // pads hold the pull-ups on so a floating input reads high
    assign o_pullup_en   = `PULLUP_ON;

endmodule

// file: jtag_boundary_scan_tap_checker.sv
`timescale 1ns/1ps
`include "jtag_tap_consts.svh"

// watches the top ports in both clock domains
module jtag_boundary_scan_tap_checker (
    input wire logic                   i_clock,       // system clock
    input wire logic                   i_reset,       // system reset
    input wire logic                   i_tck,         // test clock
    input wire logic                   i_trst_n,      // test reset
    input wire logic                   i_tms,         // mode select
    input wire logic                   i_tdi,         // data in
    input wire logic                   o_tdo,         // data out
    input wire logic                   o_tdo_oe_n,    // tdo enable
    input wire logic [2:0]             o_pullup_en,   // pull-ups
    input wire logic                   o_test_active, // extest flag
    input wire logic [`CHAIN_PINS-1:0] i_core_out,    // core values
    input wire logic [`CHAIN_PINS-1:0] i_core_oe,     // core enables
    input wire logic [`CHAIN_PINS-1:0] o_core_in,     // to core
    input wire logic [`CHAIN_PINS-1:0] i_pad_in,      // pin levels
    input wire logic [`CHAIN_PINS-1:0] o_pad_out,     // pin values
    input wire logic [`CHAIN_PINS-1:0] o_pad_oe_n     // pin enables
);
    // pads must never float the test inputs
    property p_pullup;
        @(posedge i_clock) disable iff (i_reset) o_pullup_en == `PULLUP_ON;
    endproperty
    a_pullup: assert property (p_pullup) else $error("pull-ups off");
    // tdo released while test reset holds
    property p_trst_oe;
        @(posedge i_clock) disable iff (i_reset) !i_trst_n |-> o_tdo_oe_n;
    endproperty
    a_trst_oe: assert property (p_trst_oe) else $error("tdo driven in reset");
    // extest flag drops within the sync delay of a test reset
    property p_active_trst;
        @(posedge i_clock) disable iff (i_reset) !i_trst_n [*4] |=> !o_test_active;
    endproperty
    a_active_trst: assert property (p_active_trst) else $error("extest kept");
    // the clock-only pin never drives
    property p_in_only;
        @(posedge i_clock) disable iff (i_reset)
            o_pad_oe_n[`INPUT_ONLY_PIN] && !o_pad_out[`INPUT_ONLY_PIN];
    endproperty
    a_in_only: assert property (p_in_only) else $error("input pin driven");
    // core always sees the pins
    property p_core_in;
        @(posedge i_clock) disable iff (i_reset) o_core_in == i_pad_in;
    endproperty
    a_core_in: assert property (p_core_in) else $error("core input wrong");
    // five tms highs reach reset from anywhere, tdo released
    property p_tms_reset;
        @(posedge i_tck) disable iff (!i_trst_n) i_tms [*5] |=> o_tdo_oe_n;
    endproperty
    a_tms_reset: assert property (p_tms_reset) else $error("no tms reset");
    // tms low keeps the shift going
    property p_shift_stay;
        @(posedge i_tck) disable iff (!i_trst_n) !o_tdo_oe_n && !i_tms |=> !o_tdo_oe_n;
    endproperty
    a_shift_stay: assert property (p_shift_stay) else $error("shift left");
    // tms high leaves the shift and releases tdo
    property p_shift_exit;
        @(posedge i_tck) disable iff (!i_trst_n) !o_tdo_oe_n && i_tms |=> o_tdo_oe_n;
    endproperty
    a_shift_exit: assert property (p_shift_exit) else $error("shift kept");
endmodule

// file: jtag_test_controller.sv
`timescale 1ns/1ps
`include "jtag_tap_consts.svh"

// external scan tester; tck runs only inside frames, idles high
module jtag_test_controller (
    output logic      o_tck,      // test clock, 12 ns
    output logic      o_trst_n,   // test reset, low active
    output logic      o_tms,      // mode select
    output logic      o_tdi,      // data in
    input  wire logic i_tdo,      // data out
    input  wire logic i_tdo_oe_n  // tdo enable, low drives
);
    // lines parked at the pull-up level, reset held
    initial begin
        o_trst_n = 1'b0;
        o_tck    = 1'b1;
        o_tms    = 1'b1;
        o_tdi    = 1'b1;
    end
    // scans only run while trst is high
    task automatic set_trst(input logic v);
        o_trst_n = v;
    endtask
    // one period: drive after the rise, fall, read tdo, rise
    task automatic cyc(input logic tms, input logic tdi, output logic tdo);
        #1 o_tms = tms;
        o_tdi = tdi;
        #5 o_tck = 1'b0;
        // a released tdo reads inverted, so a late enable is seen
        #6 tdo = i_tdo_oe_n ? ~i_tdo : i_tdo;
        o_tck = 1'b1;
    endtask
    // n periods with tms held
    task automatic run(input logic tms, input int n);
        logic b;
        repeat (n) cyc(tms, 1'b1, b);
    endtask
    // idle to shift, n bits, update, idle; ir lsb first, chain from cell 165
    task automatic scan(input logic ir, input int n, input logic [`CHAIN_CELLS-1:0] din,
                        output logic [`CHAIN_CELLS-1:0] dout);
        int   i;
        logic b;
        dout = '0;
        cyc(1'b1, 1'b1, b);
        if (ir) begin
            cyc(1'b1, 1'b1, b);
        end
        run(1'b0, 2);
        for (int k = 0; k < n; k++) begin
            i = ir ? k : n - 1 - k;
            cyc(k == n - 1, din[i], dout[i]);
        end
        cyc(1'b1, 1'b1, b);
        cyc(1'b0, 1'b1, b);
    endtask
    // instruction scan, returns the captured bits
    task automatic ir(input logic [`IR_W-1:0] op, output logic [`IR_W-1:0] cap);
        logic [`CHAIN_CELLS-1:0] o;
        scan(1'b1, `IR_W, {{(`CHAIN_CELLS-`IR_W){1'b0}}, op}, o);
        cap = o[`IR_W-1:0];
    endtask
endmodule

// file: test_jtag_boundary_scan_tap.sv
`timescale 1ns/1ps
`include "jtag_tap_consts.svh"

module test_jtag_boundary_scan_tap;
    logic                    i_clock, i_reset;             // system side
    logic                    tck, trst_n, tms, tdi;        // tester lines
    logic                    tdo, tdo_oe_n, active;        // device answers
    logic [2:0]              pullup_en;                    // pad pull-ups
    logic [`CHAIN_PINS-1:0]  core_out, core_oe, pad_in;    // stimulus
    logic [`CHAIN_PINS-1:0]  core_in, pad_out, pad_oe_n;   // pin results
    logic [`CHAIN_CELLS-1:0] got, d;                       // scan data
    logic [2:0]              c3;                           // ir capture
    logic [2:0]              ops [2] = '{`IR_BYPASS, 3'h5}; // one-bit paths
    logic [15:0]             seed;                         // lfsr state
    int                      n_mismatch, tests_run;        // counters

    initial i_clock = 1'b0;
    always #12.5 i_clock = ~i_clock;

    jtag_boundary_scan_tap u_jtag_boundary_scan_tap (
        .i_clock(i_clock), .i_reset(i_reset), .i_tck(tck), .i_trst_n(trst_n),
        .i_tms(tms), .i_tdi(tdi), .o_tdo(tdo), .o_tdo_oe_n(tdo_oe_n),
        .o_pullup_en(pullup_en), .o_test_active(active), .i_core_out(core_out),
        .i_core_oe(core_oe), .o_core_in(core_in), .i_pad_in(pad_in),
        .o_pad_out(pad_out), .o_pad_oe_n(pad_oe_n));
    jtag_test_controller u_tester (.o_tck(tck), .o_trst_n(trst_n), .o_tms(tms),
        .o_tdi(tdi), .i_tdo(tdo), .i_tdo_oe_n(tdo_oe_n));

    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {1'b0, s[15:1]} ^ (s[0] ? 16'hb400 : 16'h0000);
    endfunction
    task automatic rand56(output logic [`CHAIN_PINS-1:0] v);
        repeat (4) begin
            seed = lfsr(seed);
            v = {v[39:0], seed};
        end
    endtask
    // first cell of a pin; the clock-only pin has one cell
    function automatic int base(input int p);
        return p <= `INPUT_ONLY_PIN ? 3 * p : 3 * p - 2;
    endfunction
    // expected capture: pin level, core value, core enable
    function automatic logic [`CHAIN_CELLS-1:0] cap();
        logic [`CHAIN_CELLS-1:0] v;
        for (int p = 0; p < `CHAIN_PINS; p++) begin
            v[base(p)] = pad_in[p];
            if (p != `INPUT_ONLY_PIN) begin
                v[base(p) + 1] = core_out[p];
                v[base(p) + 2] = core_oe[p];
            end
        end
        return v;
    endfunction
    task automatic check(input logic [`CHAIN_CELLS-1:0] g, input logic [`CHAIN_CELLS-1:0] e);
        tests_run++;
        if (g !== e) begin
            n_mismatch++;
            $display("Error t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic final_report();
        $display("checks=%0d mismatches=%0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // pins under extest follow the update stage (out, enable)
    task automatic chk_pads(input logic [`CHAIN_CELLS-1:0] u);
        logic [`CHAIN_PINS-1:0] eo, ee;
        for (int p = 0; p < `CHAIN_PINS; p++) begin
            eo[p] = p == `INPUT_ONLY_PIN ? 1'b0 : u[base(p) + 1];
            ee[p] = p == `INPUT_ONLY_PIN ? 1'b1 : ~u[base(p) + 2];
        end
        check({54'h0, pad_out, pad_oe_n}, {54'h0, eo, ee});
    endtask
    // normal operation: pins follow the core
    task automatic chk_func();
        logic [`CHAIN_PINS-1:0] m;
        m = ~(56'h1 << `INPUT_ONLY_PIN);
        check({54'h0, pad_out & m, ~pad_oe_n & m}, {54'h0, core_out & m, core_oe & m});
    endtask
    // bounded wait on the synchronised extest flag
    task automatic wait_active(input logic v);
        int k;
        k = 0;
        while (active !== v && k < 10) begin
            @(posedge i_clock);
            #1 k++;
        end
        if (active !== v) begin
            n_mismatch++;
            final_report();
        end
    endtask

    initial begin
        n_mismatch = 0;
        tests_run = 0;
        seed = 16'h4810;
        i_reset = 1'b1;
        rand56(core_out);
        rand56(core_oe);
        rand56(pad_in);
        repeat (4) @(posedge i_clock);
        #2 i_reset = 1'b0;
        u_tester.set_trst(1'b1);
        u_tester.run(1'b0, 1);
        // extest right after reset drives the safe constants
        u_tester.ir(`IR_EXTEST, c3);
        check({163'h0, c3}, {163'h0, 3'b001});
        wait_active(1'b1);
        chk_pads(`BSR_SAFE);
        @(posedge i_clock);
        #2 rand56(core_out);
        #1 chk_pads(`BSR_SAFE);
        // tms held high returns to normal operation
        u_tester.run(1'b1, 5);
        wait_active(1'b0);
        chk_func();
        u_tester.run(1'b0, 1);
        // capture fresh pins, shift a preload pattern in
        u_tester.ir(`IR_SAMPLE, c3);
        @(posedge i_clock);
        #2 rand56(core_out);
        rand56(core_oe);
        rand56(pad_in);
        d = {core_out[53:0], core_oe, pad_in};
        u_tester.run(1'b0, 4);
        u_tester.scan(1'b0, `CHAIN_CELLS, d, got);
        check(got, cap());
        chk_func();
        u_tester.ir(`IR_EXTEST, c3);
        #1 chk_pads(d);
        // bypass and an unused code give a one-cell path that captures 0
        foreach (ops[j]) begin
            u_tester.ir(ops[j], c3);
            @(posedge i_clock);
            #2 rand56(core_oe);
            u_tester.scan(1'b0, 8, {110'h0, core_oe}, got);
            check({158'h0, got[7:0]}, {158'h0, 1'b0, core_oe[7:1]});
        end
        // test reset mid-run clears extest and the instruction
        u_tester.ir(`IR_EXTEST, c3);
        u_tester.set_trst(1'b0);
        repeat (8) @(posedge i_clock);
        check({165'h0, tdo_oe_n}, {165'h0, 1'b1});
        wait_active(1'b0);
        u_tester.set_trst(1'b1);
        u_tester.run(1'b0, 1);
        u_tester.scan(1'b0, 8, {110'h0, core_oe}, got);
        check({158'h0, got[7:0]}, {158'h0, 1'b0, core_oe[7:1]});
        final_report();
    end
endmodule

bind jtag_boundary_scan_tap jtag_boundary_scan_tap_checker u_chk (
    .i_clock(i_clock), .i_reset(i_reset), .i_tck(i_tck), .i_trst_n(i_trst_n),
    .i_tms(i_tms), .i_tdi(i_tdi), .o_tdo(o_tdo), .o_tdo_oe_n(o_tdo_oe_n),
    .o_pullup_en(o_pullup_en), .o_test_active(o_test_active),
    .i_core_out(i_core_out), .i_core_oe(i_core_oe), .o_core_in(o_core_in),
    .i_pad_in(i_pad_in), .o_pad_out(o_pad_out), .o_pad_oe_n(o_pad_oe_n));
